/* File: mcp_pkg.sv */
package mcp_pkg;
	// --------------------------------------------------------------
	// Geometry
	// --------------------------------------------------------------
	localparam int NUM_CH = 6;
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [2:0] LAST_CH = 3'h5;
	// Divide the 24 MHz auxiliary source down to 1 MHz
	localparam logic [4:0] AUX_DIV_1MHZ = 5'h18;

	// --------------------------------------------------------------
	// Register offsets (byte addresses)
	// --------------------------------------------------------------
	localparam logic [11:0] AUX_CFG_ADDR = 12'h000;
	localparam logic [11:0] STAGE_ADDR = 12'h004;
	localparam logic [11:0] START_ADDR = 12'h008;
	localparam logic [11:0] CHANGE_ADDR = 12'h00C;
	localparam logic [11:0] CH_BASE_ADDR = 12'h010;
	localparam logic [11:0] CH_STRIDE = 12'h004;

	// --------------------------------------------------------------
	// Field positions
	// --------------------------------------------------------------
	localparam int AUX_EN_BIT = 0;
	localparam int AUX_1M_BIT = 1;
	localparam int AUX_XTAL_BIT = 2;
	localparam int STAGE_TOG_LSB = 0;
	localparam int STAGE_INI_LSB = 16;
	localparam int CMD_IDX_LSB = 0;
	localparam int CMD_SEL_BIT = 3;
	localparam int CMD_POL_BIT = 4;
	localparam int CH_OUT_BIT = 16;
	localparam int CH_EN_BIT = 17;
	localparam int CH_SEL_BIT = 18;
	localparam int CH_POL_BIT = 19;
	localparam int CH_ROUTE_BIT = 20;

	// --------------------------------------------------------------
	// Reset values
	// --------------------------------------------------------------
	localparam logic [15:0] TOG_RST = 16'h0000;
	localparam logic [15:0] INI_RST = 16'h0000;
	localparam logic [31:0] RDATA_RST = 32'h00000000;
endpackage

/* File: mcp_tick.sv */
`timescale 1ns/1ps
module mcp_tick #(
	parameter int DIV_W = 5
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_pin,
	input wire logic div_en,
	input wire logic [DIV_W-1:0] div_val,
	output logic tick
);
	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	typedef struct packed {
		logic [2:0] sync;
		logic lvl;
		logic [DIV_W-1:0] cnt;
		logic tick;
	} mcp_tick_t;

	mcp_tick_t st_reg;
	mcp_tick_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.sync = {st_reg.sync[1:0], clk_pin};
		st_next.tick = 1'b0;
		// Stage 0 feeds only stage 1; level moves once stages 1 and 2 agree
		if (st_reg.sync[1] == st_reg.sync[2]) begin
			st_next.lvl = st_reg.sync[2];
			if (st_reg.sync[2] && !st_reg.lvl) begin
				if (!div_en) begin
					st_next.tick = 1'b1;
				end else if (st_reg.cnt >= div_val - {{(DIV_W-1){1'b0}}, 1'b1}) begin
					st_next.cnt = '0;
					st_next.tick = 1'b1;
				end else begin
					st_next.cnt = st_reg.cnt + {{(DIV_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick = st_reg.tick;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_tick_single: assert property (tick |=> !tick)
		else $error("tick lasted more than one cycle");
endmodule

/* File: mcp_channel.sv */
`timescale 1ns/1ps
module mcp_channel #(
	parameter int CNT_W = mcp_pkg::CNT_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic enable,
	input wire logic start,
	input wire logic polarity,
	input wire logic [CNT_W-1:0] toggle,
	input wire logic [CNT_W-1:0] init,
	output logic [CNT_W-1:0] count,
	output logic out
);
	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	typedef struct packed {
		logic [CNT_W-1:0] count;
		logic out;
	} mcp_chan_t;

	mcp_chan_t st_reg;
	mcp_chan_t st_next;
	logic [CNT_W-1:0] step;

	assign step = st_reg.count + CNT_W'(mcp_pkg::CNT_ONE);

	always_comb begin
		st_next = st_reg;
		if (start) begin
			st_next.count = init;
			st_next.out = polarity;
		end else if (!enable) begin
			st_next.out = polarity;
		end else if (tick) begin
			if (st_reg.count == CNT_W'(mcp_pkg::CNT_MAX)) begin
				st_next.count = init;
				st_next.out = polarity;
			end else begin
				st_next.count = step;
				if (step == toggle) begin
					st_next.out = ~st_reg.out;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign count = st_reg.count;
	assign out = st_reg.out;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_start_load: assert property (start |=> count == $past(init) && out == $past(polarity))
		else $error("start did not load initial count and level");
	a_idle_level: assert property (!enable && !start |=> out == $past(polarity) && $stable(count))
		else $error("disabled channel moved or showed wrong level");
	a_count_step: assert property (enable && tick && !start
		&& count != CNT_W'(mcp_pkg::CNT_MAX)
		|=> count == $past(count) + CNT_W'(mcp_pkg::CNT_ONE))
		else $error("counter did not advance by one on tick");
	a_wrap_reload: assert property (enable && tick && !start
		&& count == CNT_W'(mcp_pkg::CNT_MAX)
		|=> count == $past(init) && out == $past(polarity))
		else $error("wrap did not reload initial count");
	a_toggle_flip: assert property (enable && tick && !start
		&& count != CNT_W'(mcp_pkg::CNT_MAX)
		&& count + CNT_W'(mcp_pkg::CNT_ONE) == toggle |=> out != $past(out))
		else $error("output did not invert at toggle count");
	a_no_tick_hold: assert property (enable && !tick && !start
		|=> $stable(count) && $stable(out))
		else $error("channel changed without a tick");

	c_wrap: cover property (enable && tick && count == CNT_W'(mcp_pkg::CNT_MAX));
	c_toggle: cover property (enable && tick && count + CNT_W'(mcp_pkg::CNT_ONE) == toggle);
endmodule

/* File: mcp_top.sv */
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module mcp_top #(
	parameter int ADDR_W = 12,
	parameter int NUM_CH = mcp_pkg::NUM_CH,
	parameter int CNT_W = mcp_pkg::CNT_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic lp_clk_32k,
	input wire logic aux_clock_second,
	input wire logic xtal_clk_24m,
	output logic [NUM_CH-1:0] pwm_out,
	output logic [NUM_CH-1:0] pwm_route_en
);
	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic aux_en;
		logic aux_1m;
		logic aux_xtal;
		logic [CNT_W-1:0] stage_tog;
		logic [CNT_W-1:0] stage_ini;
		logic [NUM_CH-1:0] en;
		logic [NUM_CH-1:0] sel;
		logic [NUM_CH-1:0] pol;
		logic [NUM_CH-1:0] route;
		logic [NUM_CH-1:0] ld;
		logic [NUM_CH-1:0][CNT_W-1:0] tog;
		logic [NUM_CH-1:0][CNT_W-1:0] ini;
	} mcp_top_t;

	mcp_top_t st_reg;
	mcp_top_t st_next;

	logic slow_tick;
	logic aux_tick;
	logic aux_pin;
	logic [NUM_CH-1:0] ch_tick;
	logic [NUM_CH-1:0][CNT_W-1:0] ch_count;
	logic [NUM_CH-1:0] ch_out;

	// --------------------------------------------------------------
	// Clock sources
	// --------------------------------------------------------------
	// The first auxiliary clock has no port at all: it cannot reach a channel
	assign aux_pin = st_reg.aux_xtal ? xtal_clk_24m : aux_clock_second;

	mcp_tick #(
		.DIV_W(5)
	) u_slow (
		.pclk(pclk),
		.presetn(presetn),
		.clk_pin(lp_clk_32k),
		.div_en(1'b0),
		.div_val(5'h01),
		.tick(slow_tick)
	);

	mcp_tick #(
		.DIV_W(5)
	) u_aux (
		.pclk(pclk),
		.presetn(presetn),
		.clk_pin(aux_pin),
		.div_en(st_reg.aux_1m),
		.div_val(mcp_pkg::AUX_DIV_1MHZ),
		.tick(aux_tick)
	);

	// --------------------------------------------------------------
	// Channels
	// --------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
			// Auxiliary ticks are dropped until software has enabled that clock
			assign ch_tick[gi] = st_reg.sel[gi] ? (aux_tick & st_reg.aux_en) : slow_tick;
			mcp_channel #(
				.CNT_W(CNT_W)
			) u_ch (
				.pclk(pclk),
				.presetn(presetn),
				.tick(ch_tick[gi]),
				.enable(st_reg.en[gi]),
				.start(st_reg.ld[gi]),
				.polarity(st_reg.pol[gi]),
				.toggle(st_reg.tog[gi]),
				.init(st_reg.ini[gi]),
				.count(ch_count[gi]),
				.out(ch_out[gi])
			);
		end
	endgenerate

	// --------------------------------------------------------------
	// Register bus
	// --------------------------------------------------------------
	logic acc_first;
	logic acc_last;
	logic [2:0] cmd_idx;
	logic cmd_ok;

	// One wait state: ready rises in the second access cycle, writes land there
	assign acc_first = psel && penable && !st_reg.pready;
	assign acc_last = psel && penable && st_reg.pready;
	assign cmd_idx = pwdata[mcp_pkg::CMD_IDX_LSB +: 3];
	assign cmd_ok = cmd_idx <= mcp_pkg::LAST_CH;

	always_comb begin
		logic [ADDR_W-1:0] ch_addr;
		logic hit;
		ch_addr = '0;
		hit = 1'b0;
		st_next = st_reg;
		st_next.ld = '0;
		st_next.pready = 1'b0;
		st_next.pslverr = 1'b0;
		if (acc_first) begin
			st_next.pready = 1'b1;
			st_next.prdata = mcp_pkg::RDATA_RST;
			case (paddr)
				ADDR_W'(mcp_pkg::AUX_CFG_ADDR): begin
					hit = 1'b1;
					st_next.prdata[mcp_pkg::AUX_EN_BIT] = st_reg.aux_en;
					st_next.prdata[mcp_pkg::AUX_1M_BIT] = st_reg.aux_1m;
					st_next.prdata[mcp_pkg::AUX_XTAL_BIT] = st_reg.aux_xtal;
				end
				ADDR_W'(mcp_pkg::STAGE_ADDR): begin
					hit = 1'b1;
					st_next.prdata = {st_reg.stage_ini, st_reg.stage_tog};
				end
				ADDR_W'(mcp_pkg::START_ADDR), ADDR_W'(mcp_pkg::CHANGE_ADDR): begin
					hit = 1'b1;
				end
				default: begin
				end
			endcase
			for (int i = 0; i < NUM_CH; i++) begin
				ch_addr = ADDR_W'(mcp_pkg::CH_BASE_ADDR) + ADDR_W'(i) * ADDR_W'(mcp_pkg::CH_STRIDE);
				if (paddr == ch_addr) begin
					hit = 1'b1;
					st_next.prdata[CNT_W-1:0] = ch_count[i];
					st_next.prdata[mcp_pkg::CH_OUT_BIT] = ch_out[i];
					st_next.prdata[mcp_pkg::CH_EN_BIT] = st_reg.en[i];
					st_next.prdata[mcp_pkg::CH_SEL_BIT] = st_reg.sel[i];
					st_next.prdata[mcp_pkg::CH_POL_BIT] = st_reg.pol[i];
					st_next.prdata[mcp_pkg::CH_ROUTE_BIT] = st_reg.route[i];
				end
			end
			st_next.pslverr = !hit;
		end else if (acc_last && pwrite) begin
			case (paddr)
				ADDR_W'(mcp_pkg::AUX_CFG_ADDR): begin
					st_next.aux_en = pwdata[mcp_pkg::AUX_EN_BIT];
					st_next.aux_1m = pwdata[mcp_pkg::AUX_1M_BIT];
					st_next.aux_xtal = pwdata[mcp_pkg::AUX_XTAL_BIT];
				end
				ADDR_W'(mcp_pkg::STAGE_ADDR): begin
					st_next.stage_tog = pwdata[mcp_pkg::STAGE_TOG_LSB +: CNT_W];
					st_next.stage_ini = pwdata[mcp_pkg::STAGE_INI_LSB +: CNT_W];
				end
				ADDR_W'(mcp_pkg::START_ADDR): begin
					if (cmd_ok) begin
						// Whole start in one write: parameters, enable, load, route
						st_next.tog[cmd_idx] = st_reg.stage_tog;
						st_next.ini[cmd_idx] = st_reg.stage_ini;
						st_next.sel[cmd_idx] = pwdata[mcp_pkg::CMD_SEL_BIT];
						st_next.pol[cmd_idx] = pwdata[mcp_pkg::CMD_POL_BIT];
						st_next.en[cmd_idx] = 1'b1;
						st_next.route[cmd_idx] = 1'b1;
						st_next.ld[cmd_idx] = 1'b1;
					end
				end
				ADDR_W'(mcp_pkg::CHANGE_ADDR): begin
					if (cmd_ok) begin
						// No reload here, so a shortened period may glitch once
						st_next.tog[cmd_idx] = st_reg.stage_tog;
						st_next.ini[cmd_idx] = st_reg.stage_ini;
					end
				end
				default: begin
				end
			endcase
			for (int i = 0; i < NUM_CH; i++) begin
				ch_addr = ADDR_W'(mcp_pkg::CH_BASE_ADDR) + ADDR_W'(i) * ADDR_W'(mcp_pkg::CH_STRIDE);
				// Writing a zero enable stops the channel; restart goes through start
				if (paddr == ch_addr && !pwdata[mcp_pkg::CH_EN_BIT]) begin
					st_next.en[i] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.tog <= {NUM_CH{mcp_pkg::TOG_RST}};
			st_reg.ini <= {NUM_CH{mcp_pkg::INI_RST}};
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign pwm_out = ch_out;
	assign pwm_route_en = st_reg.route;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_apb_wait: assert property (psel && penable && !pready |=> pready)
		else $error("access phase not answered after one wait state");
	a_apb_pulse: assert property (pready |=> !pready)
		else $error("ready held beyond one cycle");
	a_start_all: assert property (psel && penable && pready && pwrite
		&& paddr == ADDR_W'(mcp_pkg::START_ADDR) && pwdata[2:0] <= mcp_pkg::LAST_CH
		|=> st_reg.ld[$past(pwdata[2:0])] && st_reg.en[$past(pwdata[2:0])]
		&& pwm_route_en[$past(pwdata[2:0])])
		else $error("start did not load, enable and route the channel");
	a_bad_index: assert property (psel && penable && pready && pwrite
		&& paddr == ADDR_W'(mcp_pkg::START_ADDR) && pwdata[2:0] > mcp_pkg::LAST_CH
		|=> st_reg.ld == '0)
		else $error("out of range index touched a channel");
	a_live_change: assert property (psel && penable && pready && pwrite
		&& paddr == ADDR_W'(mcp_pkg::CHANGE_ADDR) && pwdata[2:0] <= mcp_pkg::LAST_CH
		|=> st_reg.ld == '0 && st_reg.tog[$past(pwdata[2:0])] == $past(st_reg.stage_tog))
		else $error("live change restarted or missed the channel");
	a_aux_gate: assert property (!st_reg.aux_en |-> (ch_tick & st_reg.sel) == 6'h00)
		else $error("auxiliary tick passed while auxiliary clock disabled");
	a_route_sticky: assert property (pwm_route_en != '0
		|=> (pwm_route_en & $past(pwm_route_en)) == $past(pwm_route_en))
		else $error("a routed channel lost its pin");
	a_err_data: assert property (pslverr |-> pready && prdata == mcp_pkg::RDATA_RST)
		else $error("error answer carried read data");

	// --------------------------------------------------------------
	// Per-channel checks
	// --------------------------------------------------------------
	// Each channel watches its own slot, so an index mix-up shows up as a
	// request reaching the wrong channel rather than as a wrong count later
	genvar gc;
	generate
		for (gc = 0; gc < NUM_CH; gc++) begin : g_chk
			logic [ADDR_W-1:0] own_addr;
			assign own_addr = ADDR_W'(mcp_pkg::CH_BASE_ADDR)
				+ ADDR_W'(gc) * ADDR_W'(mcp_pkg::CH_STRIDE);
			a_stop_write: assert property (acc_last && pwrite && paddr == own_addr
				&& !pwdata[mcp_pkg::CH_EN_BIT] |=> !st_reg.en[gc])
				else $error("channel still enabled after a stop write");
			a_index_only: assert property (acc_last && pwrite && cmd_idx != 3'(gc)
				&& (paddr == ADDR_W'(mcp_pkg::START_ADDR)
				|| paddr == ADDR_W'(mcp_pkg::CHANGE_ADDR))
				|=> $stable(st_reg.tog[gc]) && $stable(st_reg.ini[gc]) && !st_reg.ld[gc])
				else $error("request reached a channel that it did not name");
			a_change_ini: assert property (acc_last && pwrite && cmd_idx == 3'(gc)
				&& paddr == ADDR_W'(mcp_pkg::CHANGE_ADDR)
				|=> st_reg.ini[gc] == $past(st_reg.stage_ini) && !st_reg.ld[gc])
				else $error("live change missed the initial count");
			a_slow_pick: assert property (st_reg.en[gc] && !st_reg.sel[gc]
				&& !st_reg.ld[gc] && !slow_tick |=> $stable(ch_count[gc]))
				else $error("slow clock channel moved without a slow tick");
		end
	endgenerate

	c_start: cover property (st_reg.ld != 6'h00);
	c_bad_addr: cover property (pslverr);
	c_aux_run: cover property (aux_tick && st_reg.aux_1m && st_reg.aux_en);
endmodule

/* File: mcp_pin_model.sv */
`timescale 1ns/1ps
module mcp_pin_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [5:0] dir_out,
	input wire logic [5:0] pwm_out,
	input wire logic [5:0] pwm_route_en,
	output logic [5:0] pin,
	output logic misuse,
	output logic [5:0][7:0] rise_cnt
);
	logic [5:0] last;

	// --------------------------------------------------------------
	// Pin level
	// --------------------------------------------------------------
	// An undriven pin flips every cycle so a stale level never passes as driven
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pin[i] = (dir_out[i] & pwm_route_en[i]) ? pwm_out[i] : ~last[i];
		end
	end

	// --------------------------------------------------------------
	// Load: counts edges only, so glitches are tolerated
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last <= 6'h00;
			misuse <= 1'b0;
			for (int i = 0; i < 6; i++) begin
				rise_cnt[i] <= 8'h00;
			end
		end else begin
			last <= pin;
			misuse <= misuse | (|(pwm_route_en & ~dir_out));
			for (int i = 0; i < 6; i++) begin
				if (pin[i] && !last[i] && dir_out[i] && pwm_route_en[i]) begin
					rise_cnt[i] <= rise_cnt[i] + 8'h01;
				end
			end
		end
	end
endmodule

/* File: multi_channel_pwm_unit_tb.sv */
`timescale 1ns/1ps
module multi_channel_pwm_unit_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic lp_clk_32k = 1'b0;
	logic aux_clock_second = 1'b0;
	logic xtal_clk_24m = 1'b0;
	logic aux_run = 1'b1;
	logic [5:0] pwm_out;
	logic [5:0] pwm_route_en;
	logic [5:0] dir_out = 6'h00;
	logic [5:0] pin;
	logic misuse;
	logic [5:0][7:0] rise_cnt;
	logic [31:0] rd;
	logic err;
	logic [15:0] held;
	logic low_seen;
	int num_errors = 0;
	int samples_checked = 0;

	always #2 pclk = ~pclk;
	always #15625 lp_clk_32k = ~lp_clk_32k;
	always #20.833 aux_clock_second = aux_run ? ~aux_clock_second : aux_clock_second;
	always #20.8 xtal_clk_24m = ~xtal_clk_24m;

	mcp_top mcp_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .lp_clk_32k, .aux_clock_second, .xtal_clk_24m, .pwm_out,
		.pwm_route_en);
	mcp_pin_model mcp_pin_model_i (.pclk, .presetn, .dir_out, .pwm_out, .pwm_route_en, .pin,
		.misuse, .rise_cnt);

	// --------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------
	task automatic stop_test();
		$display("errors %0d, checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_near(input int got, input int exp, input int tol);
		samples_checked++;
		if (got < exp - tol || got > exp + tol) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			num_errors++;
			stop_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [11:0] cha(input int i);
		return mcp_pkg::CH_BASE_ADDR + mcp_pkg::CH_STRIDE * 12'(i);
	endfunction

	task automatic start(input int ch, input logic sel, input logic pol,
		input logic [15:0] tog, input logic [15:0] ini);
		apb(1'b1, mcp_pkg::STAGE_ADDR, {ini, tog});
		apb(1'b1, mcp_pkg::START_ADDR, {27'h0, pol, sel, 3'(ch)});
	endtask

	// Cycles between two counter steps; polling costs four cycles per read
	task automatic meas(input int ch, input int exp, input int tol);
		logic [15:0] c0;
		realtime t0;
		int n;
		apb(1'b0, cha(ch), 32'h0);
		c0 = rd[15:0];
		n = 0;
		while (rd[15:0] === c0 && n < 4000) begin
			apb(1'b0, cha(ch), 32'h0);
			n++;
		end
		t0 = $realtime;
		c0 = rd[15:0];
		while (rd[15:0] === c0 && n < 8000) begin
			apb(1'b0, cha(ch), 32'h0);
			n++;
		end
		if (n >= 8000) begin
			num_errors++;
			stop_test();
		end
		chk_near(int'(($realtime - t0) / 4.0), exp, tol);
	endtask

	// --------------------------------------------------------------
	// Sequence
	// --------------------------------------------------------------
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, cha(0), 32'h0);
		chk(rd, 32'h00000000);
		apb(1'b0, 12'h100, 32'h0);
		chk({31'h0, err}, 32'h1);
		dir_out <= 6'h3F;
		apb(1'b1, mcp_pkg::AUX_CFG_ADDR, 32'h1);
		// Clock ratio 6, duty 50 percent
		start(2, 1'b1, 1'b1, 16'hFFFF - 16'h0002, 16'hFFFF - 16'h0005);
		apb(1'b0, cha(2), 32'h0);
		chk(rd[31:17], 32'hF);
		for (int i = 0; i < 6; i++) begin
			if (i != 2) begin
				apb(1'b0, cha(i), 32'h0);
				chk(rd, 32'h00000000);
			end
		end
		repeat (40) begin
			apb(1'b0, cha(2), 32'h0);
			chk(rd[16], rd[15:0] < 16'hFFFD);
			chk(rd[15:0] >= 16'hFFFA, 32'h1);
		end
		chk(rise_cnt[2] != 8'h00, 32'h1);
		apb(1'b1, mcp_pkg::STAGE_ADDR, {16'hFFFF - 16'h000F, 16'hFFFF - 16'h0004});
		apb(1'b0, mcp_pkg::STAGE_ADDR, 32'h0);
		chk(rd, 32'hFFF0FFFB);
		apb(1'b1, mcp_pkg::CHANGE_ADDR, 32'h2);
		apb(1'b0, mcp_pkg::START_ADDR, 32'h0);
		chk(rd, 32'h00000000);
		repeat (300) @(posedge pclk);
		low_seen = 1'b0;
		repeat (40) begin
			apb(1'b0, cha(2), 32'h0);
			low_seen = low_seen | (rd[15:0] < 16'hFFFA);
			chk(rd[16], rd[15:0] < 16'hFFFB);
		end
		chk(low_seen, 32'h1);
		apb(1'b1, mcp_pkg::AUX_CFG_ADDR, 32'h3);
		apb(1'b0, mcp_pkg::AUX_CFG_ADDR, 32'h0);
		chk(rd, 32'h00000003);
		meas(2, 250, 8);
		aux_run <= 1'b0;
		apb(1'b1, mcp_pkg::AUX_CFG_ADDR, 32'h7);
		meas(2, 250, 8);
		start(0, 1'b0, 1'b0, 16'hFFFF, 16'hFFFE);
		apb(1'b0, cha(0), 32'h0);
		chk(rd, 32'h0012FFFE);
		meas(0, 7812, 16);
		apb(1'b1, cha(2), 32'h0);
		apb(1'b0, cha(2), 32'h0);
		held = rd[15:0];
		chk(rd[20:16], 32'h1D);
		repeat (600) @(posedge pclk);
		apb(1'b0, cha(2), 32'h0);
		chk(rd[15:0], held);
		start(6, 1'b1, 1'b1, 16'h1234, 16'h0000);
		apb(1'b0, cha(5), 32'h0);
		chk(rd, 32'h00000000);
		chk({31'h0, misuse}, 32'h0);
		stop_test();
	end

	initial begin
		repeat (100000) @(posedge pclk);
		num_errors++;
		stop_test();
	end
endmodule
